// >>> rtl/mic_params.svh
// Constants for the interrupt controller: register byte offsets,
// field positions, reset values, edge codes, vector addresses.
// Assumes a 200 MHz system clock and an 8-bit register map on AXI4-Lite.
// Summary of operation
// - Pulse-timer register: four match flags in bits 7..4, enables in 3..0
// - Second register: EEPROM flag 6, timer A/P flags 5,4; enables 2,1,0
// - Third register: audio-timer B/A/P flags 6..4, enables 2..0
// - Bits 7 and 3 of second and third registers read zero, ignore writes
// - A source event sets its flag regardless of any enable
// - A flag branches only when its enable is one; otherwise just stays set
// - Global enable at zero suppresses every interrupt branch
// - On entry push next-instruction address, then load the winning vector
// - Return-from-interrupt pops the saved address and resumes
// - Taking any interrupt clears the global enable; software may re-set it
// - Requests arriving while blocked still set and keep their flags
// - No interrupt is acknowledged while the return stack is full
// - Simultaneous enabled requests are served in fixed priority order
// - Any flag becoming set wakes the device from sleep or idle
// - Each external pin sets its flag on its selected transition type
// - Serving an external pin interrupt clears its flag and global enable
// - A/D completion sets its flag; branch needs global and A/D enables
// - Serving the A/D interrupt clears its flag and the global enable
// - Three group interrupts fed by timer-match and EEPROM member flags
// - Edge code 00 off, 01 rising, 10 falling, 11 both edges
// - Group flag sets when an enabled member flag becomes set
// - Group branch needs global, member and group enables, stack not full
// - Group service clears only the group flag, member flags stay set
`ifndef MIC_PARAMS_SVH
`define MIC_PARAMS_SVH

`define MIC_ADDR_GCTRL 8'h00
`define MIC_ADDR_EXT 8'h04
`define MIC_ADDR_EDGE 8'h08
`define MIC_ADDR_ADC 8'h0c
`define MIC_ADDR_GRP 8'h10
`define MIC_ADDR_PULSE_TIMER_MATCH_IRQ_CTRL 8'h14
`define MIC_ADDR_EEPROM_STD_TIMER_IRQ_CTRL 8'h18
`define MIC_ADDR_AUDIO_TIMER_MATCH_IRQ_CTRL 8'h1c
`define MIC_ADDR_STAT 8'h20

`define MIC_RESET_BYTE 8'h00
`define MIC_UNIMPL_MASK 8'h77

`define MIC_EDGE_OFF 2'b00
`define MIC_EDGE_RISE 2'b01
`define MIC_EDGE_FALL 2'b10
`define MIC_EDGE_BOTH 2'b11

`define MIC_RESP_OKAY 2'b00
`define MIC_RESP_DECERR 2'b11

// Priority index 0 is served first
`define MIC_SRC_EXT0 3'h0
`define MIC_SRC_EXT1 3'h1
`define MIC_SRC_ADC 3'h2
`define MIC_SRC_GRP0 3'h3
`define MIC_SRC_GRP1 3'h4
`define MIC_SRC_GRP2 3'h5
`define MIC_SRC_EXT2 3'h6
`define MIC_SRC_EXT3 3'h7

`define MIC_VEC_EXT0 13'h0004
`define MIC_VEC_EXT1 13'h0008
`define MIC_VEC_ADC 13'h000c
`define MIC_VEC_GRP0 13'h0010
`define MIC_VEC_GRP1 13'h0014
`define MIC_VEC_GRP2 13'h0018
`define MIC_VEC_EXT2 13'h001c
`define MIC_VEC_EXT3 13'h0020

`endif

// >>> rtl/mic_pkg.sv
// Types for the interrupt controller: sequencer phases, event carrier
// and the whole register state of the controller as one struct.
// Assumes mic_params.svh is included by the design file.
package mic_pkg;

    typedef enum logic [1:0] {
        MIC_PH_IDLE,
        MIC_PH_PUSH,
        MIC_PH_LOAD
    } mic_phase_type;

    // One-cycle event pulses from on-chip sources, same clock
    typedef struct packed {
        logic [3:0] ptimer;
        logic [1:0] stimer;
        logic eeprom_done;
        logic [2:0] atimer;
        logic adc_done;
    } mic_evt_type;

    typedef struct packed {
        logic global_irq_en;
        logic [3:0] ext_pin_irq_flags;
        logic [3:0] ext_pin_irq_enables;
        logic [7:0] ext_edge_select_reg;
        logic adc_done_flag;
        logic adc_done_en;
        logic [2:0] group_irq_flag;
        logic [2:0] group_irq_en;
        logic [2:0] group_term;
        logic [3:0] pt_flag;
        logic [3:0] pt_en;
        logic [2:0] st_flag;
        logic [2:0] st_en;
        logic [2:0] at_flag;
        logic [2:0] at_en;
        logic [3:0] pin_s1;
        logic [3:0] pin_s2;
        logic [3:0] pin_q;
        mic_phase_type phase;
        logic [2:0] win;
        logic [12:0] push_data;
        logic [12:0] vector;
        logic push;
        logic load;
        logic pop;
        logic wake;
        logic aw_full;
        logic [7:0] awaddr;
        logic w_full;
        logic [7:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
    } mic_state_type;

endpackage : mic_pkg

// >>> rtl/mic_top.sv
// Interrupt controller: flags, enables, edge detect, priority and the
// push/load sequence toward the core, registers on AXI4-Lite.
// Assumes core strobes and event pulses run on mclk_i; pins are async.
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "mic_params.svh"

module mic_top
    import mic_pkg::*;
(
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire mic_evt_type evt_i,
    input wire logic [3:0] ext_irq_pins_i,
    input wire logic boundary_i,
    input wire logic stack_full_i,
    input wire logic [12:0] next_pc_i,
    input wire logic return_from_irq_instr_i,
    output logic push_o,
    output logic [12:0] push_pc_o,
    output logic load_pc_o,
    output logic [12:0] pc_vector_o,
    output logic pop_o,
    output logic wake_o,
    output logic irq_pending_o
);

    // ==========================================================
    // State
    // ==========================================================
    mic_state_type st;
    mic_state_type next_st;

    logic [7:0] pend;
    logic [2:0] winner;
    logic take;
    logic wr_go;
    logic [3:0] rise;
    logic [3:0] fall;
    logic [3:0] hit;
    logic [2:0] term;
    logic [7:0] rd_val;
    logic rd_hit;
    logic [12:0] vec_sel;
    logic [31:0] all_now;
    logic [31:0] all_next;

    // ==========================================================
    // Pending requests and priority
    // ==========================================================
    always_comb begin
        pend = 8'h00;
        pend[`MIC_SRC_EXT0] = st.ext_pin_irq_flags[0] & st.ext_pin_irq_enables[0];
        pend[`MIC_SRC_EXT1] = st.ext_pin_irq_flags[1] & st.ext_pin_irq_enables[1];
        pend[`MIC_SRC_ADC] = st.adc_done_flag & st.adc_done_en;
        pend[`MIC_SRC_GRP0] = st.group_irq_flag[0] & st.group_irq_en[0];
        pend[`MIC_SRC_GRP1] = st.group_irq_flag[1] & st.group_irq_en[1];
        pend[`MIC_SRC_GRP2] = st.group_irq_flag[2] & st.group_irq_en[2];
        pend[`MIC_SRC_EXT2] = st.ext_pin_irq_flags[2] & st.ext_pin_irq_enables[2];
        pend[`MIC_SRC_EXT3] = st.ext_pin_irq_flags[3] & st.ext_pin_irq_enables[3];
    end

    // Lowest index wins; scanning downward leaves the last hit
    always_comb begin
        winner = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (pend[i]) begin
                winner = 3'(i);
            end
        end
    end

    always_comb begin
        case (st.win)
            `MIC_SRC_EXT0: vec_sel = `MIC_VEC_EXT0;
            `MIC_SRC_EXT1: vec_sel = `MIC_VEC_EXT1;
            `MIC_SRC_ADC: vec_sel = `MIC_VEC_ADC;
            `MIC_SRC_GRP0: vec_sel = `MIC_VEC_GRP0;
            `MIC_SRC_GRP1: vec_sel = `MIC_VEC_GRP1;
            `MIC_SRC_GRP2: vec_sel = `MIC_VEC_GRP2;
            `MIC_SRC_EXT2: vec_sel = `MIC_VEC_EXT2;
            default: vec_sel = `MIC_VEC_EXT3;
        endcase
    end

    // Stack full holds off acknowledge but never touches the flags
    assign take = (st.phase == MIC_PH_IDLE) && boundary_i && !stack_full_i
        && st.global_irq_en && (|pend);

    // ==========================================================
    // Edge detection on synchronised pins
    // ==========================================================
    assign rise = st.pin_s2 & ~st.pin_q;
    assign fall = ~st.pin_s2 & st.pin_q;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            case (st.ext_edge_select_reg[2*i +: 2])
                `MIC_EDGE_RISE: hit[i] = rise[i];
                `MIC_EDGE_FALL: hit[i] = fall[i];
                `MIC_EDGE_BOTH: hit[i] = rise[i] | fall[i];
                default: hit[i] = 1'b0;
            endcase
        end
    end

    // Group term is any enabled member; its rising edge sets the group
    assign term[0] = |(st.pt_flag & st.pt_en);
    assign term[1] = |(st.st_flag & st.st_en);
    assign term[2] = |(st.at_flag & st.at_en);

    // ==========================================================
    // Register read mux
    // ==========================================================
    always_comb begin
        rd_hit = 1'b1;
        case (s_axi_araddr_i)
            `MIC_ADDR_GCTRL: rd_val = {7'h00, st.global_irq_en};
            `MIC_ADDR_EXT: rd_val = {st.ext_pin_irq_flags, st.ext_pin_irq_enables};
            `MIC_ADDR_EDGE: rd_val = st.ext_edge_select_reg;
            `MIC_ADDR_ADC: rd_val = {6'h00, st.adc_done_flag, st.adc_done_en};
            `MIC_ADDR_GRP: rd_val = {1'b0, st.group_irq_flag, 1'b0, st.group_irq_en};
            `MIC_ADDR_PULSE_TIMER_MATCH_IRQ_CTRL: rd_val = {st.pt_flag, st.pt_en};
            `MIC_ADDR_EEPROM_STD_TIMER_IRQ_CTRL: rd_val = {1'b0, st.st_flag, 1'b0, st.st_en};
            `MIC_ADDR_AUDIO_TIMER_MATCH_IRQ_CTRL: rd_val = {1'b0, st.at_flag, 1'b0, st.at_en};
            `MIC_ADDR_STAT: rd_val = {5'h00, (st.phase != MIC_PH_IDLE), (|pend), stack_full_i};
            default: begin
                rd_val = `MIC_RESET_BYTE;
                rd_hit = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // Next state
    // ==========================================================
    assign wr_go = st.aw_full && st.w_full && !st.bvalid;

    always_comb begin
        next_st = st;
        next_st.push = 1'b0;
        next_st.load = 1'b0;
        next_st.pop = return_from_irq_instr_i;
        next_st.pin_s1 = ext_irq_pins_i;
        next_st.pin_s2 = st.pin_s1;
        next_st.pin_q = st.pin_s2;

        // Bus write: address and data taken in either order
        if (!st.aw_full && s_axi_awvalid_i) begin
            next_st.aw_full = 1'b1;
            next_st.awaddr = s_axi_awaddr_i;
        end
        if (!st.w_full && s_axi_wvalid_i) begin
            next_st.w_full = 1'b1;
            next_st.wdata = s_axi_wdata_i[7:0];
            next_st.wstrb0 = s_axi_wstrb_i[0];
        end
        if (st.bvalid && s_axi_bready_i) begin
            next_st.bvalid = 1'b0;
        end
        if (wr_go) begin
            next_st.aw_full = 1'b0;
            next_st.w_full = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = `MIC_RESP_OKAY;
            case (st.awaddr)
                `MIC_ADDR_GCTRL: begin
                    if (st.wstrb0) next_st.global_irq_en = st.wdata[0];
                end
                `MIC_ADDR_EXT: begin
                    if (st.wstrb0) begin
                        next_st.ext_pin_irq_flags = st.wdata[7:4];
                        next_st.ext_pin_irq_enables = st.wdata[3:0];
                    end
                end
                `MIC_ADDR_EDGE: begin
                    if (st.wstrb0) next_st.ext_edge_select_reg = st.wdata;
                end
                `MIC_ADDR_ADC: begin
                    if (st.wstrb0) begin
                        next_st.adc_done_flag = st.wdata[1];
                        next_st.adc_done_en = st.wdata[0];
                    end
                end
                `MIC_ADDR_GRP: begin
                    if (st.wstrb0) begin
                        next_st.group_irq_flag = st.wdata[6:4];
                        next_st.group_irq_en = st.wdata[2:0];
                    end
                end
                `MIC_ADDR_PULSE_TIMER_MATCH_IRQ_CTRL: begin
                    if (st.wstrb0) begin
                        next_st.pt_flag = st.wdata[7:4];
                        next_st.pt_en = st.wdata[3:0];
                    end
                end
                `MIC_ADDR_EEPROM_STD_TIMER_IRQ_CTRL: begin
                    if (st.wstrb0) begin
                        next_st.st_flag = st.wdata[6:4];
                        next_st.st_en = st.wdata[2:0];
                    end
                end
                `MIC_ADDR_AUDIO_TIMER_MATCH_IRQ_CTRL: begin
                    if (st.wstrb0) begin
                        next_st.at_flag = st.wdata[6:4];
                        next_st.at_en = st.wdata[2:0];
                    end
                end
                `MIC_ADDR_STAT: begin
                    next_st.bresp = `MIC_RESP_OKAY;
                end
                default: begin
                    next_st.bresp = `MIC_RESP_DECERR;
                end
            endcase
        end

        // Bus read
        if (!st.rvalid && s_axi_arvalid_i) begin
            next_st.rvalid = 1'b1;
            next_st.rdata = rd_val;
            next_st.rresp = rd_hit ? `MIC_RESP_OKAY : `MIC_RESP_DECERR;
        end else if (st.rvalid && s_axi_rready_i) begin
            next_st.rvalid = 1'b0;
        end

        // Entry sequence: take, push, load; service clears beat a write
        case (st.phase)
            MIC_PH_IDLE: begin
                if (take) begin
                    next_st.phase = MIC_PH_PUSH;
                    next_st.win = winner;
                    next_st.global_irq_en = 1'b0;
                    next_st.push = 1'b1;
                    next_st.push_data = next_pc_i;
                    case (winner)
                        `MIC_SRC_EXT0: next_st.ext_pin_irq_flags[0] = 1'b0;
                        `MIC_SRC_EXT1: next_st.ext_pin_irq_flags[1] = 1'b0;
                        `MIC_SRC_ADC: next_st.adc_done_flag = 1'b0;
                        `MIC_SRC_GRP0: next_st.group_irq_flag[0] = 1'b0;
                        `MIC_SRC_GRP1: next_st.group_irq_flag[1] = 1'b0;
                        `MIC_SRC_GRP2: next_st.group_irq_flag[2] = 1'b0;
                        `MIC_SRC_EXT2: next_st.ext_pin_irq_flags[2] = 1'b0;
                        default: next_st.ext_pin_irq_flags[3] = 1'b0;
                    endcase
                end
            end
            MIC_PH_PUSH: begin
                next_st.phase = MIC_PH_LOAD;
                next_st.load = 1'b1;
                next_st.vector = vec_sel;
            end
            MIC_PH_LOAD: begin
                next_st.phase = MIC_PH_IDLE;
            end
            default: begin
                next_st.phase = MIC_PH_IDLE;
            end
        endcase

        // Hardware sets come last so an event is never lost to a clear
        next_st.ext_pin_irq_flags = next_st.ext_pin_irq_flags | hit;
        next_st.adc_done_flag = next_st.adc_done_flag | evt_i.adc_done;
        next_st.pt_flag = next_st.pt_flag | evt_i.ptimer;
        next_st.st_flag = next_st.st_flag | {evt_i.eeprom_done, evt_i.stimer};
        next_st.at_flag = next_st.at_flag | evt_i.atimer;
        next_st.group_term = term;
        next_st.group_irq_flag = next_st.group_irq_flag | (term & ~st.group_term);

        // Wake on any flag going from clear to set
        all_next = {14'h0000, next_st.ext_pin_irq_flags, next_st.adc_done_flag,
            next_st.group_irq_flag, next_st.pt_flag, next_st.st_flag, next_st.at_flag};
        next_st.wake = |(all_next & ~all_now);
    end

    assign all_now = {14'h0000, st.ext_pin_irq_flags, st.adc_done_flag,
        st.group_irq_flag, st.pt_flag, st.st_flag, st.at_flag};

    // ==========================================================
    // Register
    // ==========================================================
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            st <= '0;
            st.phase <= MIC_PH_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign s_axi_awready_o = !st.aw_full;
    assign s_axi_wready_o = !st.w_full;
    assign s_axi_bvalid_o = st.bvalid;
    assign s_axi_bresp_o = st.bresp;
    assign s_axi_arready_o = !st.rvalid;
    assign s_axi_rvalid_o = st.rvalid;
    assign s_axi_rresp_o = st.rresp;
    assign s_axi_rdata_o = {24'h000000, st.rdata};
    assign push_o = st.push;
    assign push_pc_o = st.push_data;
    assign load_pc_o = st.load;
    assign pc_vector_o = st.vector;
    assign pop_o = st.pop;
    assign wake_o = st.wake;
    assign irq_pending_o = st.global_irq_en && (|pend);

    // ==========================================================
    // Assertions
    // ==========================================================
    gie_gates_entry_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        (st.phase == MIC_PH_PUSH) |-> $past(st.global_irq_en))
        else $error("entry taken with global enable clear");

    entry_clears_gie_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        (st.phase == MIC_PH_IDLE && take) |=> !st.global_irq_en)
        else $error("global enable not cleared on entry");

    stack_full_hold_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        (st.phase == MIC_PH_IDLE && stack_full_i) |=> (st.phase == MIC_PH_IDLE))
        else $error("interrupt taken with full stack");

    push_then_load_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        push_o |=> load_pc_o ##1 !load_pc_o)
        else $error("vector load does not follow push");

    vector_matches_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        load_pc_o |-> (pc_vector_o == vec_sel))
        else $error("vector does not match winner");

    adc_event_flag_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        evt_i.adc_done |=> st.adc_done_flag)
        else $error("A/D event lost");

    ext_rise_flag_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        (rise[0] && st.ext_edge_select_reg[1:0] == `MIC_EDGE_RISE) |=> st.ext_pin_irq_flags[0])
        else $error("rising edge did not set pin flag");

    unimpl_zero_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        (s_axi_arvalid_i && !st.rvalid && s_axi_araddr_i == `MIC_ADDR_AUDIO_TIMER_MATCH_IRQ_CTRL)
        |=> ((s_axi_rdata_o[7:0] & ~`MIC_UNIMPL_MASK) == 8'h00))
        else $error("unimplemented bits read nonzero");

    flag_wakes_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        $rose(st.adc_done_flag) |-> wake_o)
        else $error("flag set without wake");

    group_keeps_member_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        (take && winner == `MIC_SRC_GRP0 && !wr_go && !(|evt_i.ptimer))
        |=> (st.pt_flag == $past(st.pt_flag)))
        else $error("group service cleared member flags");

endmodule : mic_top
`default_nettype wire

// >>> bench/mic_core_model.sv
// Core-side model: instruction boundary, stack-full level,
// next-instruction address and return-from-interrupt strobe.
// Assumes the bench requests a full stack or a return by its inputs.
`timescale 1ns/1ps
`default_nettype none
module mic_core_model
    import mic_pkg::*;
(
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic full_req_i,
    input wire logic ret_req_i,
    output logic boundary_o,
    output logic stack_full_o,
    output logic [12:0] next_pc_o,
    output logic return_from_irq_instr_o
);
    // ==========
    // Core sequencing
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            next_pc_o <= 13'h0000;
            boundary_o <= 1'h0;
            stack_full_o <= 1'h0;
            return_from_irq_instr_o <= 1'h0;
        end else begin
            // Address moves each cycle so a stale pushed address shows
            next_pc_o <= next_pc_o + 13'h0001;
            boundary_o <= 1'h1;
            stack_full_o <= full_req_i;
            return_from_irq_instr_o <= ret_req_i;
        end
    end
endmodule : mic_core_model
`default_nettype wire

// >>> bench/mic_top_tb.sv
// Bench for mic_top: AXI4-Lite tasks, event pulses, pin edges.
// Assumes mic_pkg compiled and mic_params.svh on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "mic_params.svh"
module mic_top_tb;
    import mic_pkg::*;
    logic mclk_i = 1'h0;
    logic reset_i = 1'h1;
    logic [7:0] awa, ara;
    logic [31:0] wd, rdat, rdv;
    logic awv, wv, bre, arv, rre, awr, wr_o, bv, arr, rv;
    logic [1:0] bresp, rresp, bq, rq;
    mic_evt_type evt;
    logic [3:0] pins;
    logic fullq, retq, bnd, sfull, return_from_irq_instr, push, load, pop, wake, pend;
    logic [12:0] npc, ppc, vec, lvec, pcq;
    int fails = 0, cmp_count = 0, takes = 0, pops = 0, wakes = 0;

    mic_top dut_u (.mclk_i(mclk_i), .reset_i(reset_i), .s_axi_awaddr_i(awa),
        .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
        .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_o),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(bre),
        .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
        .s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
        .s_axi_rready_i(rre), .evt_i(evt), .ext_irq_pins_i(pins), .boundary_i(bnd),
        .stack_full_i(sfull), .next_pc_i(npc), .return_from_irq_instr_i(return_from_irq_instr), .push_o(push),
        .push_pc_o(ppc), .load_pc_o(load), .pc_vector_o(vec), .pop_o(pop),
        .wake_o(wake), .irq_pending_o(pend));
    mic_core_model core_u (.mclk_i(mclk_i), .reset_i(reset_i), .full_req_i(fullq),
        .ret_req_i(retq), .boundary_o(bnd), .stack_full_o(sfull), .next_pc_o(npc),
        .return_from_irq_instr_o(return_from_irq_instr));

    always #2.5 mclk_i = ~mclk_i;

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task stop_test;
        $display("fails=%0d cmp_count=%0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    // ==========
    // Bus tasks: valid and payload held until their own ready edge
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        awa <= a;
        wd <= {24'h000000, d};
        awv <= 1'h1;
        wv <= 1'h1;
        bre <= 1'h1;
        forever begin
            @(posedge mclk_i);
            if (awr) awv <= 1'h0;
            if (wr_o) wv <= 1'h0;
            if (bv) break;
        end
        bq = bresp;
        bre <= 1'h0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge mclk_i);
        ara <= a;
        arv <= 1'h1;
        rre <= 1'h1;
        forever begin
            @(posedge mclk_i);
            if (arr) arv <= 1'h0;
            if (rv) break;
        end
        rdv = rdat;
        rq = rresp;
        rre <= 1'h0;
    endtask : rd
    task ev(input mic_evt_type e);
        @(posedge mclk_i);
        evt <= e;
        @(posedge mclk_i);
        evt <= '0;
        repeat (3) @(posedge mclk_i);
    endtask : ev
    task wt(input logic [12:0] v);
        int t0, n;
        t0 = takes;
        n = 0;
        while (takes == t0 && n < 40) begin
            @(posedge mclk_i);
            n++;
        end
        chk(32'(takes - t0), 32'h1);
        chk(32'(lvec), 32'(v));
    endtask : wt
    // Entry monitor: pushed address must be the one offered at take
    always @(posedge mclk_i) begin
        pcq <= npc;
        if (push) chk(32'(ppc), 32'(pcq));
        if (load) takes++;
        if (load) lvec = vec;
        if (pop) pops++;
        if (wake) wakes++;
    end
    initial begin
        #200000;
        fails++;
        stop_test();
    end

    initial begin
        mic_evt_type e;
        int w0;
        {awv, wv, bre, arv, rre, fullq, retq} = '0;
        awa = '0; ara = '0; wd = '0; evt = '0; pins = '0;
        repeat (12) @(posedge mclk_i);
        reset_i <= 1'h0;
        for (int i = 0; i < 3; i++) begin
            rd(8'(`MIC_ADDR_PULSE_TIMER_MATCH_IRQ_CTRL + 4 * i));
            chk(rdv, 32'h0);
            wr(8'(`MIC_ADDR_PULSE_TIMER_MATCH_IRQ_CTRL + 4 * i), 8'hff);
            rd(8'(`MIC_ADDR_PULSE_TIMER_MATCH_IRQ_CTRL + 4 * i));
            chk(rdv, (i == 0) ? 32'hff : 32'h77);
            wr(8'(`MIC_ADDR_PULSE_TIMER_MATCH_IRQ_CTRL + 4 * i), 8'h00);
        end
        wr(`MIC_ADDR_GRP, 8'h00);
        rd(8'h40);
        chk(32'(rq), 32'(`MIC_RESP_DECERR));
        wr(8'h40, 8'h01);
        chk(32'(bq), 32'(`MIC_RESP_DECERR));
        // Request while blocked: flag kept, one wake, no entry
        wr(`MIC_ADDR_ADC, 8'h01);
        w0 = wakes;
        e = '0;
        e.adc_done = 1'h1;
        ev(e);
        rd(`MIC_ADDR_ADC);
        chk(rdv, 32'h3);
        chk(32'(wakes - w0), 32'h1);
        fullq <= 1'h1;
        wr(`MIC_ADDR_GCTRL, 8'h01);
        repeat (10) @(posedge mclk_i);
        chk(32'(takes), 32'h0);
        chk(32'(pend), 32'h1);
        rd(`MIC_ADDR_STAT);
        chk(rdv, 32'h3);
        fullq <= 1'h0;
        wt(`MIC_VEC_ADC);
        rd(`MIC_ADDR_ADC);
        chk(rdv, 32'h1);
        rd(`MIC_ADDR_GCTRL);
        chk(rdv, 32'h0);
        retq <= 1'h1;
        @(posedge mclk_i);
        retq <= 1'h0;
        repeat (4) @(posedge mclk_i);
        chk(32'(pops), 32'h1);
        // Group member and A/D pending together
        wr(`MIC_ADDR_PULSE_TIMER_MATCH_IRQ_CTRL, 8'h01);
        wr(`MIC_ADDR_GRP, 8'h01);
        e.ptimer = 4'h1;
        ev(e);
        rd(`MIC_ADDR_GRP);
        chk(rdv, 32'h11);
        wr(`MIC_ADDR_GCTRL, 8'h01);
        wt(`MIC_VEC_ADC);
        wr(`MIC_ADDR_GCTRL, 8'h01);
        wt(`MIC_VEC_GRP0);
        rd(`MIC_ADDR_GRP);
        chk(rdv, 32'h1);
        rd(`MIC_ADDR_PULSE_TIMER_MATCH_IRQ_CTRL);
        chk(rdv, 32'h11);
        wr(`MIC_ADDR_PULSE_TIMER_MATCH_IRQ_CTRL, 8'h01);
        // Every edge code on pin 0, enable still off
        for (int c = 0; c < 4; c++) begin
            wr(`MIC_ADDR_EDGE, 8'(c));
            wr(`MIC_ADDR_EXT, 8'h00);
            pins[0] <= 1'h1;
            repeat (8) @(posedge mclk_i);
            rd(`MIC_ADDR_EXT);
            chk(32'(rdv[4]), 32'(c[0]));
            pins[0] <= 1'h0;
            repeat (8) @(posedge mclk_i);
            rd(`MIC_ADDR_EXT);
            chk(32'(rdv[4]), 32'(c[0] | c[1]));
        end
        wr(`MIC_ADDR_GCTRL, 8'h01);
        repeat (10) @(posedge mclk_i);
        chk(32'(takes), 32'h3);
        wr(`MIC_ADDR_EXT, 8'h11);
        wt(`MIC_VEC_EXT0);
        rd(`MIC_ADDR_EXT);
        chk(rdv, 32'h1);
        rd(`MIC_ADDR_GCTRL);
        chk(rdv, 32'h0);
        // EEPROM completion and audio-timer match feed groups one and two
        wr(`MIC_ADDR_EEPROM_STD_TIMER_IRQ_CTRL, 8'h04);
        wr(`MIC_ADDR_AUDIO_TIMER_MATCH_IRQ_CTRL, 8'h04);
        wr(`MIC_ADDR_GRP, 8'h06);
        e = '0;
        e.eeprom_done = 1'h1;
        e.atimer = 3'h4;
        ev(e);
        wr(`MIC_ADDR_GCTRL, 8'h01);
        wt(`MIC_VEC_GRP1);
        wr(`MIC_ADDR_GCTRL, 8'h01);
        wt(`MIC_VEC_GRP2);
        rd(`MIC_ADDR_EEPROM_STD_TIMER_IRQ_CTRL);
        chk(rdv, 32'h44);
        rd(`MIC_ADDR_AUDIO_TIMER_MATCH_IRQ_CTRL);
        chk(rdv, 32'h44);
        stop_test();
    end
endmodule : mic_top_tb
`default_nettype wire
